// ===== dual_pot_defines.svh
// Operation
// - Data changes only while clock low; changes with clock high are start/stop.
// - Watch for start at all times; ignore everything before a start.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Acknowledge address, instruction byte and any following data byte.
// - Lower four address bits must equal the four address-select pins.
// - Stop after nonvolatile write starts internal write; inputs disabled meanwhile.
// - While internal write runs, address is not acknowledged; afterwards it is.
// - Instruction byte: upper nibble opcode, lower nibble pot and register pointers.
// - Bit two picks the pot; two low bits pick one of four registers.
// - Four register transfer instructions finish with the instruction byte.
// - Data-to-wiper transfer is volatile; tap follows after wiper settle delay.
// - Wiper-to-data transfer is a nonvolatile write taking the write time.
// - Transfers work for one pot or both pots with the same index.
// - Read/write wiper and read/write data use a third data byte.
// - Increment mode: clock pulse with data high steps toward high terminal.
// - Increment mode: clock pulse with data low steps toward low terminal.
// - Six wiper bits decode to exactly one of sixty-four taps per pot.
// - Wiper register loads by host write or data register copy; readable.
// - Opcodes 1001,1010,1011,1100,1101,1110 for read/write/transfer per pot.
// - Opcode 0001 global data-to-wiper, 1000 global wiper-to-data, 0010 step mode.
// - At power-up each wiper register loads from its data register zero.
// - Any nonvolatile data register change completes within ten milliseconds.
`ifndef DUAL_POT_DEFINES_SVH
`define DUAL_POT_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_RD_WIPER      4'h9
`define OP_WR_WIPER      4'hA
`define OP_RD_DATA       4'hB
`define OP_WR_DATA       4'hC
`define OP_XFR_TO_WIPER  4'hD
`define OP_XFR_TO_DATA   4'hE
`define OP_GXFR_TO_WIPER 4'h1
`define OP_GXFR_TO_DATA  4'h8
`define OP_INCDEC        4'h2

// ----------------------------------------
// Field values and resets
// ----------------------------------------
`define WIPER_MAX        6'h3F
`define WIPER_MIN        6'h00
`define DR_RESET         6'h00
`define BIT_LAST         4'h7
`define BIT_ACK          4'h8
`define SYNC_RESET       6'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS        5
`define NV_WRITE_TIME_MS     5
`define NV_WRITE_CYCLES      ((`NV_WRITE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define WIPER_SETTLE_TIME_NS 500
`define WIPER_SETTLE_CYCLES  \
    ((`WIPER_SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== dual_pot_pkg.sv
package dual_pot_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [5:0]        wiper_t;
    typedef logic [1:0][63:0]  taps_t;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ADDR   = 7'h02,
        ST_INSTR  = 7'h04,
        ST_RX     = 7'h08,
        ST_TX     = 7'h10,
        ST_INCDEC = 7'h20,
        ST_WAIT   = 7'h40
    } state_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic       zero_bit;
        logic       pot_select_bit;
        logic       register_index_high;
        logic       register_index_low;
    } instr_t;

endpackage : dual_pot_pkg

// ===== pot_wiper_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "dual_pot_defines.svh"

module pot_wiper_stage
    import dual_pot_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    input  wire wiper_t wcr_i,
    output logic [63:0] tap_o
);

    wiper_t     shown_r;
    logic [7:0] settle_r;

    // ----------------------------------------
    // Settle delay, then one-hot tap
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            shown_r  <= `DR_RESET;
            settle_r <= 8'h00;
            tap_o    <= 64'h0000_0000_0000_0001;
        end else if (wcr_i != shown_r) begin
            if (settle_r == 8'(`WIPER_SETTLE_CYCLES - 1)) begin
                shown_r  <= wcr_i;
                settle_r <= 8'h00;
                tap_o    <= 64'h0000_0000_0000_0001 << wcr_i;
            end else begin
                settle_r <= settle_r + 8'h01;
            end
        end else begin
            settle_r <= 8'h00;
        end
    end

endmodule : pot_wiper_stage
`default_nettype wire

// ===== dual_pot_serial_command_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "dual_pot_defines.svh"

module dual_pot_serial_command_slave
    import dual_pot_pkg::*;
#(
    // Arbitrary value
    parameter logic [3:0] DEVICE_TYPE_ID  = 4'hA,
    parameter int         NV_WRITE_CYCLES = `NV_WRITE_CYCLES
)
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic [3:0] address_select_pins_i,
    output taps_t           wiper_tap_o,
    output logic            busy_o,
    output logic            incdec_active_o
);

    localparam logic [5:0] SYNC_RST = `SYNC_RESET;

    // ----------------------------------------
    // Link domain: bit taken at clock rise
    // ----------------------------------------
    logic link_bit_r;

    always_ff @(posedge scl_i) begin
        link_bit_r <= sda_i;
    end

    // ----------------------------------------
    // Pin synchronisers and filters
    // ----------------------------------------
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [5:0] s3_r;
    logic [5:0] filt_r;
    logic       scl_q_r;
    logic       sda_q_r;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
        end else begin
            s1_r <= {address_select_pins_i, sda_i, scl_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_filt
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    filt_r[gi] <= SYNC_RST[gi];
                end else if (s2_r[gi] == s3_r[gi]) begin
                    filt_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= filt_r[0];
            sda_q_r <= filt_r[1];
        end
    end

    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    logic       scl_f;
    logic       sda_f;
    logic [3:0] addr_f;
    logic       start_ev;
    logic       stop_ev;
    logic       rise_ev;
    logic       fall_ev;

    assign scl_f    = filt_r[0];
    assign sda_f    = filt_r[1];
    assign addr_f   = filt_r[5:2];
    assign start_ev = scl_f & scl_q_r & sda_q_r & ~sda_f;
    assign stop_ev  = scl_f & scl_q_r & ~sda_q_r & sda_f;
    assign rise_ev  = scl_f & ~scl_q_r;
    assign fall_ev  = ~scl_f & scl_q_r;

    // ----------------------------------------
    // Byte assembly
    // ----------------------------------------
    state_t     st_r;
    logic [3:0] cnt_r;
    logic [6:0] sh_r;
    logic [7:0] byte_w;
    instr_t     ins_w;
    instr_t     instr_r;
    logic       byte_done;
    logic       ack_clk;
    logic       ack_r;
    logic       busy_r;
    logic       addr_hit;
    logic       op_ok;

    assign byte_w    = {sh_r, link_bit_r};
    assign ins_w     = instr_t'(byte_w);
    assign byte_done = rise_ev && (cnt_r == `BIT_LAST);
    assign ack_clk   = rise_ev && (cnt_r == `BIT_ACK);
    assign addr_hit  = (byte_w[7:4] == DEVICE_TYPE_ID)
                     && (byte_w[3:0] == addr_f)
                     && !busy_r;

    always_comb begin
        case (ins_w.opcode)
            `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_DATA, `OP_WR_DATA,
            `OP_XFR_TO_WIPER, `OP_XFR_TO_DATA, `OP_GXFR_TO_WIPER,
            `OP_GXFR_TO_DATA, `OP_INCDEC: op_ok = 1'b1;
            default: op_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || start_ev || stop_ev) begin
            cnt_r <= 4'h0;
            sh_r  <= 7'h00;
        end else if (rise_ev) begin
            sh_r  <= byte_w[6:0];
            cnt_r <= (cnt_r == `BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    // ----------------------------------------
    // Acknowledge decision
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i || start_ev || stop_ev) begin
            ack_r <= 1'b0;
        end else if (byte_done) begin
            case (st_r)
                ST_ADDR:  ack_r <= addr_hit;
                ST_INSTR: ack_r <= op_ok;
                ST_RX:    ack_r <= 1'b1;
                default:  ack_r <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            instr_r <= instr_t'(8'h00);
        end else if (byte_done && st_r == ST_INSTR) begin
            instr_r <= ins_w;
        end
    end

    // ----------------------------------------
    // Command state
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r <= ST_IDLE;
        end else if (start_ev) begin
            st_r <= ST_ADDR;
        end else if (stop_ev) begin
            st_r <= ST_IDLE;
        end else if (ack_clk) begin
            case (st_r)
                ST_ADDR:  st_r <= ack_r ? ST_INSTR : ST_WAIT;
                ST_INSTR: begin
                    if (!ack_r) begin
                        st_r <= ST_WAIT;
                    end else begin
                        case (instr_r.opcode)
                            `OP_RD_WIPER, `OP_RD_DATA: st_r <= ST_TX;
                            `OP_WR_WIPER, `OP_WR_DATA: st_r <= ST_RX;
                            `OP_INCDEC: st_r <= ST_INCDEC;
                            default:    st_r <= ST_WAIT;
                        endcase
                    end
                end
                ST_RX, ST_TX: st_r <= ST_WAIT;
                default:      st_r <= st_r;
            endcase
        end
    end

    // ----------------------------------------
    // Registers of both pots
    // ----------------------------------------
    wiper_t     wcr_r [2];
    wiper_t     dr_r  [2][4];
    logic       recall_r;
    logic [1:0] pend_mask_r;
    logic [1:0] pend_idx_r;
    wiper_t     pend_val_r [2];
    logic [1:0] ins_idx;
    logic [1:0] cur_idx;
    logic       ins_pot;
    logic       cur_pot;

    assign ins_idx = {ins_w.register_index_high, ins_w.register_index_low};
    assign cur_idx = {instr_r.register_index_high,
                      instr_r.register_index_low};
    assign ins_pot = ins_w.pot_select_bit;
    assign cur_pot = instr_r.pot_select_bit;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wcr_r[0] <= `DR_RESET;
            wcr_r[1] <= `DR_RESET;
            recall_r <= 1'b1;
        end else if (recall_r) begin
            wcr_r[0] <= dr_r[0][0];
            wcr_r[1] <= dr_r[1][0];
            recall_r <= 1'b0;
        end else if (byte_done && st_r == ST_INSTR) begin
            if (ins_w.opcode == `OP_XFR_TO_WIPER) begin
                wcr_r[ins_pot] <= dr_r[ins_pot][ins_idx];
            end else if (ins_w.opcode == `OP_GXFR_TO_WIPER) begin
                wcr_r[0] <= dr_r[0][ins_idx];
                wcr_r[1] <= dr_r[1][ins_idx];
            end
        end else if (byte_done && st_r == ST_RX
                     && instr_r.opcode == `OP_WR_WIPER) begin
            wcr_r[cur_pot] <= byte_w[5:0];
        end else if (rise_ev && st_r == ST_INCDEC) begin
            if (link_bit_r) begin
                if (wcr_r[cur_pot] != `WIPER_MAX) begin
                    wcr_r[cur_pot] <= wcr_r[cur_pot] + 6'h01;
                end
            end else if (wcr_r[cur_pot] != `WIPER_MIN) begin
                wcr_r[cur_pot] <= wcr_r[cur_pot] - 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || start_ev) begin
            pend_mask_r <= 2'h0;
            pend_idx_r  <= 2'h0;
        end else if (byte_done && st_r == ST_INSTR) begin
            pend_idx_r <= ins_idx;
            if (ins_w.opcode == `OP_XFR_TO_DATA) begin
                pend_mask_r[ins_pot] <= 1'b1;
                pend_val_r[ins_pot]  <= wcr_r[ins_pot];
            end else if (ins_w.opcode == `OP_GXFR_TO_DATA) begin
                pend_mask_r <= 2'h3;
                pend_val_r[0] <= wcr_r[0];
                pend_val_r[1] <= wcr_r[1];
            end
        end else if (byte_done && st_r == ST_RX
                     && instr_r.opcode == `OP_WR_DATA) begin
            pend_mask_r[cur_pot] <= 1'b1;
            pend_val_r[cur_pot]  <= byte_w[5:0];
            pend_idx_r           <= cur_idx;
        end else if (stop_ev) begin
            pend_mask_r <= 2'h0;
        end
    end

    generate
        for (gi = 0; gi < 2; gi++) begin : g_dr
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    dr_r[gi][0] <= `DR_RESET;
                    dr_r[gi][1] <= `DR_RESET;
                    dr_r[gi][2] <= `DR_RESET;
                    dr_r[gi][3] <= `DR_RESET;
                end else if (stop_ev && pend_mask_r[gi]) begin
                    dr_r[gi][pend_idx_r] <= pend_val_r[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Nonvolatile write busy timer
    // ----------------------------------------
    logic [19:0] nv_cnt_r;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            busy_r   <= 1'b0;
            nv_cnt_r <= 20'h0_0000;
        end else if (stop_ev && (|pend_mask_r)) begin
            busy_r   <= 1'b1;
            nv_cnt_r <= 20'(NV_WRITE_CYCLES - 1);
        end else if (busy_r) begin
            if (nv_cnt_r == 20'h0_0000) begin
                busy_r <= 1'b0;
            end else begin
                nv_cnt_r <= nv_cnt_r - 20'h0_0001;
            end
        end
    end

    // ----------------------------------------
    // Read data and line drive
    // ----------------------------------------
    logic [7:0] tx_sh_r;
    logic       drive_r;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_sh_r <= 8'h00;
        end else if (ack_clk && st_r == ST_INSTR) begin
            if (instr_r.opcode == `OP_RD_WIPER) begin
                tx_sh_r <= {2'h0, wcr_r[cur_pot]};
            end else begin
                tx_sh_r <= {2'h0, dr_r[cur_pot][cur_idx]};
            end
        end else if (rise_ev && st_r == ST_TX) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || start_ev || stop_ev) begin
            drive_r <= 1'b0;
        end else if (fall_ev) begin
            if (cnt_r == `BIT_ACK) begin
                drive_r <= ack_r;
            end else if (st_r == ST_TX) begin
                drive_r <= ~tx_sh_r[7];
            end else begin
                drive_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Wiper taps
    // ----------------------------------------
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pot
            pot_wiper_stage u_stage (
                .clk_i    (clk_i),
                .resetn_i (resetn_i),
                .wcr_i    (wcr_r[gi]),
                .tap_o    (wiper_tap_o[gi])
            );
        end
    endgenerate

    assign sda_o           = 1'b0;
    assign sda_oe_n_o      = ~drive_r;
    assign busy_o          = busy_r;
    assign incdec_active_o = (st_r == ST_INCDEC);

endmodule : dual_pot_serial_command_slave
`default_nettype wire

// ===== pot_slave_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pot_slave_monitor
    import dual_pot_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = 1000
)
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_n_o,
    input wire logic [3:0] address_select_pins_i,
    input wire taps_t      wiper_tap_o,
    input wire logic       busy_o,
    input wire logic       incdec_active_o
);
    // ------------------------------
    // Busy length counter
    // ------------------------------
    int unsigned busy_cnt_r;
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !busy_o) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_reset_idle;
        @(posedge clk_i) disable iff (1'b0)
        !resetn_i |=> sda_oe_n_o && !busy_o && !incdec_active_o
            && wiper_tap_o[0] == 64'h1 && wiper_tap_o[1] == 64'h1;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
    property p_tap_onehot;
        $onehot(wiper_tap_o[0]) && $onehot(wiper_tap_o[1]);
    endproperty
    a_tap_onehot: assert property (p_tap_onehot)
        else $error("tap select not one-hot");
    property p_pull_low;
        sda_o == 1'b0;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("data output not low");
    property p_busy_len;
        $fell(busy_o) |-> busy_cnt_r == NV_WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_busy_max;
        busy_cnt_r <= NV_WRITE_CYCLES;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("write cycle too long");
    property p_busy_nack;
        busy_o |-> sda_oe_n_o && !incdec_active_o;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("device active during write cycle");
    property p_ack_hold;
        $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("pull-down too short");
    property p_drive_scl_low;
        $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2);
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low)
        else $error("data changed with clock high");
    property p_step_end;
        incdec_active_o && scl_i && $past(scl_i) && $changed(sda_i)
            |-> ##[1:10] !incdec_active_o;
    endproperty
    a_step_end: assert property (p_step_end)
        else $error("step mode not ended");

    c_busy: cover property ($rose(busy_o));
    c_step: cover property ($rose(incdec_active_o));
    c_ack: cover property ($fell(sda_oe_n_o));
endmodule : pot_slave_monitor

bind dual_pot_serial_command_slave pot_slave_monitor #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) pot_slave_monitor_i (
    .clk_i                 (clk_i),
    .resetn_i              (resetn_i),
    .scl_i                 (scl_i),
    .sda_i                 (sda_i),
    .sda_o                 (sda_o),
    .sda_oe_n_o            (sda_oe_n_o),
    .address_select_pins_i (address_select_pins_i),
    .wiper_tap_o           (wiper_tap_o),
    .busy_o                (busy_o),
    .incdec_active_o       (incdec_active_o)
);
`default_nettype wire

// ===== bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master (
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ------------------------------
    // Bus phases, 36 ns each
    // ------------------------------
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic half();
        repeat (3) @(posedge lclk_i);
    endtask : half
    task automatic lower();
        scl_o <= 1'b0;
        half();
    endtask : lower
    task automatic start_c();
        sda_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b0;
        half();
    endtask : start_c
    task automatic stop_c();
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_o <= 1'b1;
        half();
    endtask : stop_c
    task automatic bit_x(input logic b, output logic r);
        sda_o <= b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
        half();
    endtask : bit_x
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : byte_tx
    task automatic byte_rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(1'b1, r);
    endtask : byte_rx
endmodule : bus_master
`default_nettype wire

// ===== dual_pot_serial_command_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module dual_pot_serial_command_slave_test
    import dual_pot_pkg::*;
;
    localparam int         NV   = 1000;
    localparam logic [3:0] PINS = 4'h6;
    localparam logic [7:0] ADDR = {4'hA, PINS};
    typedef struct packed {
        logic [7:0] ins;
        logic [7:0] d;
    } row_t;
    row_t rows [4] = '{'{8'hA0, 8'h00}, '{8'hA4, 8'h3F},
                       '{8'hA0, 8'hD5}, '{8'hA4, 8'h3E}};
    logic  clk_i = 1'b0;
    logic  lclk = 1'b0;
    logic  resetn_i = 1'b0;
    logic  scl, m_sda, sda_o, sda_oe_n_o, busy_o, incdec_active_o;
    taps_t wiper_tap_o;
    wire   sda_line = m_sda & (sda_oe_n_o | sda_o);
    int    err_count = 0;
    int    cmp_count = 0;
    logic  a, r, p;
    logic [7:0] q;
    wiper_t w;

    always #2.5 clk_i = ~clk_i;
    always #6 lclk = ~lclk;

    dual_pot_serial_command_slave #(
        .DEVICE_TYPE_ID  (4'hA),
        .NV_WRITE_CYCLES (NV)
    ) dual_pot_serial_command_slave_i (
        .clk_i                 (clk_i),
        .resetn_i              (resetn_i),
        .scl_i                 (scl),
        .sda_i                 (sda_line),
        .sda_o                 (sda_o),
        .sda_oe_n_o            (sda_oe_n_o),
        .address_select_pins_i (PINS),
        .wiper_tap_o           (wiper_tap_o),
        .busy_o                (busy_o),
        .incdec_active_o       (incdec_active_o)
    );
    bus_master bus_master_i (
        .lclk_i (lclk),
        .sda_i  (sda_line),
        .scl_o  (scl),
        .sda_o  (m_sda)
    );

    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic results();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic cmd(input logic [7:0] ins, input int n,
                       input logic [7:0] d, output logic [7:0] rd);
        logic k;
        rd = 8'h00;
        bus_master_i.start_c();
        bus_master_i.byte_tx(ADDR, k);
        `CHK("addr ack", 1'b1, k)
        bus_master_i.byte_tx(ins, k);
        `CHK("instr ack", 1'b1, k)
        if (n == 1) begin
            bus_master_i.byte_tx(d, k);
            `CHK("data ack", 1'b1, k)
        end
        if (n == 2) bus_master_i.byte_rx(rd);
        bus_master_i.stop_c();
        repeat (120) @(posedge clk_i);
    endtask : cmd
    task automatic wait_nv();
        `CHK("busy", 1'b1, busy_o)
        for (int i = 0; i < NV + 50 && busy_o; i++) @(posedge clk_i);
        `CHK("busy end", 1'b0, busy_o)
    endtask : wait_nv

    initial begin
        #400000;
        err_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK("tap0", 64'h1, wiper_tap_o[0])
        `CHK("tap1", 64'h1, wiper_tap_o[1])
        `CHK("idle", 3'b100, {sda_oe_n_o, busy_o, incdec_active_o})
        $display("reset done");
        bus_master_i.lower();
        bus_master_i.byte_tx(ADDR, a);
        `CHK("no start", 1'b0, a)
        bus_master_i.stop_c();
        bus_master_i.start_c();
        bus_master_i.byte_tx({4'hA, PINS ^ 4'h1}, a);
        `CHK("pins", 1'b0, a)
        bus_master_i.stop_c();
        $display("address done");
        foreach (rows[k]) begin
            w = rows[k].d[5:0];
            p = rows[k].ins[2];
            cmd(rows[k].ins, 1, rows[k].d, q);
            `CHK("tap", 64'h1 << w, wiper_tap_o[p])
            cmd({4'h9, 1'b0, p, 2'b00}, 2, 8'h00, q);
            `CHK("read wiper", {2'b00, w}, q)
        end
        $display("rows done");
        cmd(8'hC2, 1, 8'h2A, q);
        bus_master_i.start_c();
        bus_master_i.byte_tx(ADDR, a);
        `CHK("poll", 1'b0, a)
        bus_master_i.stop_c();
        wait_nv();
        cmd(8'hB2, 2, 8'h00, q);
        `CHK("read data", 8'h2A, q)
        cmd(8'hD2, 0, 8'h00, q);
        `CHK("xfer tap", 64'h1 << 42, wiper_tap_o[0])
        cmd(8'hE7, 0, 8'h00, q);
        wait_nv();
        cmd(8'hB7, 2, 8'h00, q);
        `CHK("saved", 8'h3E, q)
        $display("transfer done");
        cmd(8'h81, 0, 8'h00, q);
        wait_nv();
        cmd(8'hA0, 1, 8'h00, q);
        cmd(8'hA4, 1, 8'h00, q);
        cmd(8'h11, 0, 8'h00, q);
        `CHK("global0", 64'h1 << 42, wiper_tap_o[0])
        `CHK("global1", 64'h1 << 62, wiper_tap_o[1])
        $display("global done");
        bus_master_i.start_c();
        bus_master_i.byte_tx(ADDR, a);
        bus_master_i.byte_tx(8'h24, a);
        `CHK("step ack", 1'b1, a)
        for (int i = 0; i < 5; i++) bus_master_i.bit_x(i < 3, r);
        `CHK("step mode", 1'b1, incdec_active_o)
        bus_master_i.stop_c();
        repeat (120) @(posedge clk_i);
        `CHK("step end", 1'b0, incdec_active_o)
        // 62: up, up (held at 63), up, then down three times
        // Stop's own clock pulse, taken with data low, is the third step down
        `CHK("step tap", 64'h1 << 60, wiper_tap_o[1])
        $display("step done");
        results();
    end
endmodule : dual_pot_serial_command_slave_test
`default_nettype wire
